// ### rtl/blink_gen.sv
// Square-wave flasher with a programmable half period.
// Assumes a free-running system clock; output is low while disabled.
`timescale 1ns/10ps
`default_nettype none

module blink_gen #(
  parameter int unsigned HALF = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control
  input wire logic en,
  output logic blink
);

  typedef struct packed {
    logic [31:0] cnt;
    logic out;
  } blink_st_t;

  blink_st_t s;
  blink_st_t next_s;

  always_comb
  begin
    next_s = s;
    if (!en)
    begin
      next_s = '0;
    end
    else if (s.cnt == 32'(HALF - 1))
    begin
      next_s.cnt = '0;
      next_s.out = ~s.out;
    end
    else
    begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign blink = s.out;

endmodule
`default_nettype wire

// ### rtl/logr_house.sv
// Housekeeping top: display blanking, indicators, modem and receiver power.
// Assumes all inputs synchronous to sys_clk and a single-cycle strobe bus.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module logr_house #(
  parameter int unsigned SEC_CYC = logr_pkg::SEC_CYC,
  parameter int unsigned HB_HALF = logr_pkg::HB_HALF_CYC,
  parameter int unsigned MB_HALF = logr_pkg::MB_HALF_CYC,
  parameter int unsigned GB_HALF = logr_pkg::GB_HALF_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [logr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Keypad and display
  input wire logic key_press,
  output logic display_on,
  // Modem
  input wire logic modem_reg,
  output logic int_modem_pwr,
  output logic ext_com_pwr,
  output logic com_route_ext,
  // Positioning receiver and host link
  input wire logic gps_fix,
  input wire logic gps_utc_valid,
  input wire logic [logr_pkg::SEC_W-1:0] gps_utc_sec,
  input wire logic [logr_pkg::DAY_W-1:0] gps_utc_day,
  input wire logic rt_link_up,
  output logic gps_pwr,
  // Indicators
  output logic led_modem,
  output logic led_cpu,
  output logic led_gps,
  // Timestamp
  output logic [logr_pkg::SEC_W-1:0] time_sec,
  output logic [logr_pkg::DAY_W-1:0] time_day
);

  import logr_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic disp;
    logic [7:0] idle;
    logic gps;
    logic started;
    logic synced;
    logic link_q;
    logic [7:0] mode;
    logic [7:0] mtype;
    logic men;
    logic int_pwr;
    logic ext_pwr;
    logic route_ext;
    logic led_m;
    logic led_c;
    logic led_g;
    logic [31:0] rdata;
  } house_st_t;

  house_st_t s;
  house_st_t next_s;

  logic use_ext;
  logic powered;
  logic gps_trig;
  logic gps_end;
  logic sync_done;
  logic ld_sec;
  logic ld_day;
  logic [SEC_W-1:0] ld_sec_val;
  logic [DAY_W-1:0] ld_day_val;
  logic sec_tick;
  logic blink_hb;
  logic blink_mdm;
  logic blink_gps;
  logic [SEC_W-1:0] rtc_sec;
  logic [DAY_W-1:0] rtc_day;

  // ****************************************
  // Time base and flashers
  // ****************************************
  rtc_count #(
    .TICK(SEC_CYC)
  ) u_rtc (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ld_sec(ld_sec),
    .ld_sec_val(ld_sec_val),
    .ld_day(ld_day),
    .ld_day_val(ld_day_val),
    .sec(rtc_sec),
    .day(rtc_day),
    .tick(sec_tick)
  );

  blink_gen #(
    .HALF(HB_HALF)
  ) u_hb (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .en(1'b1),
    .blink(blink_hb)
  );

  blink_gen #(
    .HALF(MB_HALF)
  ) u_mdm (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .en(powered & modem_reg),
    .blink(blink_mdm)
  );

  // Third flasher reuses the same cell; area is small next to the dividers
  blink_gen #(
    .HALF(GB_HALF)
  ) u_gps (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .en(s.synced),
    .blink(blink_gps)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    next_s = s;
    powered = s.int_pwr | s.ext_pwr;
    if (s.mode[MODE_SEL_BIT])
      use_ext = s.mode[MODE_FORCE_BIT];
    else
      use_ext = (s.mtype != MODEM_TYPE_INT);
    sync_done = s.gps & gps_fix & gps_utc_valid;
    gps_trig = !s.started;
    gps_trig = gps_trig | (key_press & !s.disp);
    gps_trig = gps_trig | (rt_link_up & !s.link_q);
    gps_trig = gps_trig | (sec_tick & (rtc_sec == SEC_W'(SYNC_SEC)));
    gps_end = sync_done | (!rt_link_up & s.link_q);
    ld_sec = 1'b0;
    ld_day = 1'b0;
    ld_sec_val = gps_utc_sec;
    ld_day_val = gps_utc_day;

    next_s.started = 1'b1;
    next_s.link_q = rt_link_up;

    if (key_press)
    begin
      next_s.idle = '0;
      next_s.disp = 1'b1;
    end
    else if (s.disp && sec_tick)
    begin
      if (s.idle == 8'(DISP_TIMEOUT_S - 1))
      begin
        next_s.disp = 1'b0;
        next_s.idle = '0;
      end
      else
        next_s.idle = s.idle + 8'h01;
    end

    if (gps_trig)
      next_s.gps = 1'b1;
    else if (gps_end)
      next_s.gps = 1'b0;

    if (sync_done)
    begin
      ld_sec = 1'b1;
      ld_day = 1'b1;
      next_s.synced = 1'b1;
    end

    // Register writes; receiver time beats a software time write
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_MODE: next_s.mode = reg_wdata[7:0];
        ADDR_CTRL:
        begin
          next_s.mtype = reg_wdata[7:0];
          next_s.men = reg_wdata[CTRL_EN_BIT];
        end
        ADDR_TSEC:
        begin
          if (!sync_done)
          begin
            ld_sec = 1'b1;
            ld_sec_val = reg_wdata[SEC_W-1:0];
          end
        end
        ADDR_TDAY:
        begin
          if (!sync_done)
          begin
            ld_day = 1'b1;
            ld_day_val = reg_wdata[DAY_W-1:0];
          end
        end
        default: ;
      endcase
    end

    next_s.int_pwr = s.men & !use_ext;
    next_s.ext_pwr = s.men & use_ext;
    next_s.route_ext = use_ext;

    if (!powered)
      next_s.led_m = 1'b0;
    else if (!modem_reg)
      next_s.led_m = 1'b1;
    else
      next_s.led_m = blink_mdm;

    next_s.led_c = s.disp | blink_hb;
    next_s.led_g = s.synced & blink_gps;

    // Read data valid only in the cycle after the strobe
    next_s.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_MODE: next_s.rdata = {24'h000000, s.mode};
        ADDR_CTRL: next_s.rdata = {23'h000000, s.men, s.mtype};
        ADDR_STATUS:
          next_s.rdata = {23'h000000, s.led_g, s.led_c, s.led_m,
                          s.ext_pwr, s.int_pwr, s.route_ext,
                          s.synced, s.gps, s.disp};
        ADDR_TSEC: next_s.rdata = {15'h0000, rtc_sec};
        ADDR_TDAY: next_s.rdata = {16'h0000, rtc_day};
        default: next_s.rdata = '0;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s <= '{disp: DISP_RST, mode: MODE_RST, mtype: MODEM_TYPE_RST,
             men: MODEM_EN_RST, default: '0};
    else
      s <= next_s;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = s.rdata;
  assign display_on = s.disp;
  assign int_modem_pwr = s.int_pwr;
  assign ext_com_pwr = s.ext_pwr;
  assign com_route_ext = s.route_ext;
  assign gps_pwr = s.gps;
  assign led_modem = s.led_m;
  assign led_cpu = s.led_c;
  assign led_gps = s.led_g;
  assign time_sec = rtc_sec;
  assign time_day = rtc_day;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  // Sync reset: also skip the edge at which the release is still sampled
  default disable iff (!nrst || !s.started);

  a_disp_timeout: assert property (
    s.disp && sec_tick && !key_press && s.idle == 8'(DISP_TIMEOUT_S - 1)
    |=> !display_on)
    else $error("display not blanked at timeout");

  a_key_wake: assert property (
    !display_on && key_press |=> display_on && gps_pwr)
    else $error("key did not wake display and receiver");

  a_modem_dark: assert property (
    !(int_modem_pwr || ext_com_pwr) |=> !led_modem)
    else $error("modem indicator lit while unpowered");

  a_modem_steady: assert property (
    (int_modem_pwr || ext_com_pwr) && !modem_reg |=> led_modem)
    else $error("modem indicator not steady");

  a_cpu_steady: assert property (
    display_on |=> led_cpu)
    else $error("cpu indicator not steady with display on");

  a_auto_internal: assert property (
    !s.mode[MODE_SEL_BIT] && s.mtype == MODEM_TYPE_INT && s.men
    |=> int_modem_pwr && !ext_com_pwr && !com_route_ext)
    else $error("type 12 did not select internal modem");

  a_force_ext: assert property (
    s.mode[MODE_SEL_BIT] && s.mode[MODE_FORCE_BIT] && s.men
    |=> ext_com_pwr && !int_modem_pwr && com_route_ext)
    else $error("forced external port not selected");

  a_gps_startup: assert property (
    $rose(s.started) |-> gps_pwr)
    else $error("receiver not powered at startup");

  a_gps_daily: assert property (
    sec_tick && rtc_sec == SEC_W'(SYNC_SEC) |=> gps_pwr)
    else $error("receiver not powered at daily sync time");

  a_utc_load: assert property (
    sync_done |=> time_sec == $past(gps_utc_sec)
                  && time_day == $past(gps_utc_day))
    else $error("receiver time not loaded");

  a_gps_off: assert property (
    sync_done && !gps_trig |=> !gps_pwr)
    else $error("receiver not powered off after sync");

endmodule
`default_nettype wire

// ### rtl/logr_pkg.sv
// Constants shared by the logger housekeeping block.
// Assumes a single 100 MHz system clock and a synchronous active-low reset.

package logr_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SEC_CYC = CLK_HZ;
  localparam int unsigned DISP_TIMEOUT_MIN = 3;
  localparam int unsigned DISP_TIMEOUT_S = DISP_TIMEOUT_MIN * 60;
  localparam int unsigned HEARTBEAT_MS = 1000;
  localparam int unsigned HB_HALF_CYC = CLK_HZ / 1000 * HEARTBEAT_MS / 2;
  localparam int unsigned MODEM_BLINK_MS = 250;
  localparam int unsigned MB_HALF_CYC = CLK_HZ / 1000 * MODEM_BLINK_MS / 2;
  localparam int unsigned GPS_BLINK_MS = 500;
  localparam int unsigned GB_HALF_CYC = CLK_HZ / 1000 * GPS_BLINK_MS / 2;

  // ****************************************
  // Time of day
  // ****************************************
  localparam int unsigned SEC_W = 17;
  localparam int unsigned DAY_W = 16;
  localparam int unsigned SEC_PER_DAY = 86400;
  localparam int unsigned SYNC_HOUR = 0;
  localparam int unsigned SYNC_MIN = 13;
  localparam int unsigned SYNC_SEC = SYNC_HOUR * 3600 + SYNC_MIN * 60;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TSEC = 8'h0C;
  localparam logic [7:0] ADDR_TDAY = 8'h10;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned MODE_SEL_BIT = 3;
  localparam int unsigned MODE_FORCE_BIT = 4;
  localparam int unsigned CTRL_EN_BIT = 8;
  localparam logic [7:0] MODEM_TYPE_INT = 8'h0C;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MODEM_TYPE_RST = 8'h0C;
  localparam logic MODEM_EN_RST = 1'b1;
  localparam logic DISP_RST = 1'b1;

endpackage

// ### rtl/rtc_count.sv
// Time-of-day and day counter with load ports.
// Assumes the flops sit on the backup supply so time survives main power loss.
`timescale 1ns/10ps
`default_nettype none

module rtc_count
  import logr_pkg::*;
#(
  parameter int unsigned TICK = SEC_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Loads
  input wire logic ld_sec,
  input wire logic [SEC_W-1:0] ld_sec_val,
  input wire logic ld_day,
  input wire logic [DAY_W-1:0] ld_day_val,
  // Time
  output logic [SEC_W-1:0] sec,
  output logic [DAY_W-1:0] day,
  output logic tick
);

  typedef struct packed {
    logic [31:0] div;
    logic [SEC_W-1:0] sec;
    logic [DAY_W-1:0] day;
    logic tick;
  } rtc_st_t;

  rtc_st_t s;
  rtc_st_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.div == 32'(TICK - 1))
    begin
      next_s.div = '0;
      next_s.tick = 1'b1;
      if (s.sec == SEC_W'(SEC_PER_DAY - 1))
      begin
        next_s.sec = '0;
        next_s.day = s.day + DAY_W'(1);
      end
      else
        next_s.sec = s.sec + SEC_W'(1);
    end
    else
      next_s.div = s.div + 32'h1;
    if (ld_sec)
    begin
      next_s.sec = ld_sec_val;
      next_s.div = '0;
    end
    if (ld_day)
      next_s.day = ld_day_val;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign sec = s.sec;
  assign day = s.day;
  assign tick = s.tick;

endmodule
`default_nettype wire

// ### testbench/gps_rx_model.sv
// Behavioural positioning receiver for the housekeeping bench.
// Assumes the bench sets the fix delay and the UTC words to report.
`timescale 1ns/10ps
`default_nettype none

module gps_rx_model (
  // Clock
  input wire logic sys_clk,
  // Supply and setup
  input wire logic pwr,
  input wire logic [15:0] lag,
  input wire logic [logr_pkg::SEC_W-1:0] sec_set,
  input wire logic [logr_pkg::DAY_W-1:0] day_set,
  // Receiver outputs
  output logic fix,
  output logic utc_valid,
  output logic [logr_pkg::SEC_W-1:0] utc_sec,
  output logic [logr_pkg::DAY_W-1:0] utc_day
);
  import logr_pkg::*;
  logic [15:0] cnt;

  initial
  begin
    cnt = 16'h0000;
    fix = 1'b0;
    utc_valid = 1'b0;
    utc_sec = '0;
    utc_day = '0;
  end

  // Words invert each cycle outside the valid pulse, so stale data matches only on every other cycle
  always @(posedge sys_clk)
  begin
    utc_valid <= pwr && cnt == lag;
    fix <= pwr && cnt >= lag;
    if (!pwr)
      cnt <= 16'h0000;
    else if (cnt != 16'hFFFF)
      cnt <= cnt + 16'h0001;
    if (pwr && cnt == lag)
    begin
      utc_sec <= sec_set;
      utc_day <= day_set;
    end
    else
    begin
      utc_sec <= ~utc_sec;
      utc_day <= ~utc_day;
    end
  end
endmodule
`default_nettype wire

// ### testbench/logr_house_tb.sv
// Self-checking bench for the logger housekeeping block.
// Assumes shortened second and flash counts set through parameters.
`timescale 1ns/10ps
`default_nettype none

module logr_house_tb;
  import logr_pkg::*;
  localparam int SC = 20;
  localparam int HB = 5;
  localparam int MB = 3;
  localparam int GB = 4;
  localparam int LIMIT = 20000;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic key_press = 1'b0;
  logic modem_reg = 1'b0;
  logic rt_link_up = 1'b0;
  logic [15:0] lag = 16'h0008;
  logic display_on, int_modem_pwr, ext_com_pwr, com_route_ext;
  logic gps_fix, gps_utc_valid, gps_pwr, led_modem, led_cpu, led_gps;
  logic [SEC_W-1:0] gps_utc_sec, time_sec;
  logic [DAY_W-1:0] gps_utc_day, time_day;
  logic [31:0] d;
  int n;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] t_mode [7] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h18, 8'h10, 8'h10};
  logic [7:0] t_type [7] = '{8'h0C, 8'h06, 8'h07, 8'h06, 8'h0C, 8'h06, 8'h0C};
  logic t_ext [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  always #5 sys_clk = ~sys_clk;

  logr_house #(.SEC_CYC(SC), .HB_HALF(HB), .MB_HALF(MB), .GB_HALF(GB)) uut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .key_press(key_press), .display_on(display_on),
    .modem_reg(modem_reg), .int_modem_pwr(int_modem_pwr),
    .ext_com_pwr(ext_com_pwr), .com_route_ext(com_route_ext),
    .gps_fix(gps_fix), .gps_utc_valid(gps_utc_valid),
    .gps_utc_sec(gps_utc_sec), .gps_utc_day(gps_utc_day),
    .rt_link_up(rt_link_up), .gps_pwr(gps_pwr), .led_modem(led_modem),
    .led_cpu(led_cpu), .led_gps(led_gps), .time_sec(time_sec),
    .time_day(time_day));

  gps_rx_model rx (
    .sys_clk(sys_clk), .pwr(gps_pwr), .lag(lag), .sec_set(17'd5000),
    .day_set(16'd321), .fix(gps_fix), .utc_valid(gps_utc_valid),
    .utc_sec(gps_utc_sec), .utc_day(gps_utc_day));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_sim();
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic key();
    @(posedge sys_clk);
    key_press <= 1'b1;
    @(posedge sys_clk);
    key_press <= 1'b0;
    #1;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return led_modem;
      1: return led_cpu;
      2: return led_gps;
      default: return gps_pwr;
    endcase
  endfunction

  // Bounded wait for a level, then compare it
  task automatic wait_lvl(input int w, input logic v, input int max);
    int i;
    for (i = 0; i < max && pick(w) !== v; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    chk(32'(pick(w)), 32'(v));
  endtask

  // Cycles between two successive changes of a flashing output
  task automatic half(input int w, output int c);
    logic v;
    int i;
    v = pick(w);
    for (i = 0; i < 200 && pick(w) === v; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    v = pick(w);
    c = 0;
    for (i = 0; i < 200 && pick(w) === v; i++)
    begin
      @(posedge sys_clk);
      #1;
      c++;
    end
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_errors++;
      $display("ERROR %0t: run did not finish", $time);
      end_sim();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'(gps_pwr), 32'h1);
    chk(32'(display_on && led_cpu), 32'h1);
    wait_lvl(3, 1'b0, 40);
    chk(32'(time_sec), 32'd5000);
    chk(32'(time_day), 32'd321);
    rd(ADDR_STATUS, d);
    chk(32'(d[2:1]), 32'h2);
    half(2, n);
    chk(32'(n), 32'(GB));
    rd(8'h40, d);
    chk(d, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_CTRL, {23'h0, 1'b1, t_type[i]});
      wr(ADDR_MODE, 32'(t_mode[i]));
      repeat (3) @(posedge sys_clk);
      #1;
      chk(32'({com_route_ext, ext_com_pwr, int_modem_pwr}),
          32'({t_ext[i], t_ext[i], !t_ext[i]}));
    end
    rd(ADDR_MODE, d);
    chk(d, 32'h00000010);
    rd(ADDR_CTRL, d);
    chk(d, 32'h0000010C);
    wait_lvl(0, 1'b1, 4);
    wr(ADDR_CTRL, 32'h0000000C);
    wait_lvl(0, 1'b0, 4);
    wr(ADDR_CTRL, 32'h0000010C);
    modem_reg <= 1'b1;
    half(0, n);
    chk(32'(n), 32'(MB));
    lag <= 16'hFFFF;
    wr(ADDR_TDAY, 32'h0000007B);
    wr(ADDR_TSEC, 32'(SYNC_SEC - 1));
    wait_lvl(3, 1'b1, 2 * SC + 5);
    chk(32'(time_sec), 32'(SYNC_SEC));
    rd(ADDR_TSEC, d);
    chk(d, 32'(SYNC_SEC));
    rd(ADDR_TDAY, d);
    chk(d, 32'h0000007B);
    lag <= 16'd30;
    wait_lvl(3, 1'b0, 40);
    lag <= 16'hFFFF;
    @(posedge sys_clk);
    rt_link_up <= 1'b1;
    wait_lvl(3, 1'b1, 3);
    @(posedge sys_clk);
    rt_link_up <= 1'b0;
    wait_lvl(3, 1'b0, 3);
    key();
    repeat (100 * SC) @(posedge sys_clk);
    key();
    repeat (170 * SC) @(posedge sys_clk);
    #1;
    chk(32'(display_on), 32'h1);
    repeat (11 * SC + 3) @(posedge sys_clk);
    #1;
    chk(32'(display_on), 32'h0);
    half(1, n);
    chk(32'(n), 32'(HB));
    key();
    chk(32'(display_on && gps_pwr), 32'h1);
    wait_lvl(1, 1'b1, 3);
    end_sim();
  end
endmodule
`default_nettype wire
